// ==== design/gcf_pkg.sv ====
/*
 * Constants and command and state types for the gate command controller that drives
 * a three-phase inverter gate driver from outside.
 * Assumes a 10 MHz reference clock and a fault line already synchronous to it.
 */
package gcf_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned NS_PER_S = 1_000_000_000;
    localparam int unsigned CLK_NS = NS_PER_S / CLK_HZ;
    // Times in nanoseconds, resume wait in seconds, as printed
    localparam int unsigned DEAD_NS = 900;
    localparam int unsigned MIN_PULSE_NS = 500;
    localparam int unsigned MIN_PERIOD_NS = 50_000; // 20 kHz
    localparam int unsigned HOLD_BUDGET_NS = 15_000;
    localparam int unsigned RESUME_WAIT_S = 2;
    // Cycle counts: least times round up, longest times round down
    localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MIN_PERIOD_CYC = (MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HOLD_BUDGET_CYC = HOLD_BUDGET_NS / CLK_NS;
    localparam int unsigned RESUME_WAIT_CYC = RESUME_WAIT_S * CLK_HZ;
    // Phase count and widths
    localparam int unsigned NPH = 3;
    localparam int unsigned DUTY_W = 10;
    localparam int unsigned CNT_W = 10;
    localparam int unsigned WAIT_W = 25;

    // Commands to one phase
    typedef struct packed {
        logic high_side_command;
        logic low_side_command;
    } gcf_phase_cmd_t;

    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_TRIP = 2'b10,
        ST_WAIT = 2'b11
    } gcf_state_t;
endpackage : gcf_pkg

// ==== design/gcf_phase.sv ====
/*
 * One phase of the command generator: turns a desired high-side level into
 * complementary commands with dead time and minimum pulse width.
 * Assumes the parent forces it off through kill_i on a fault.
 */
module gcf_phase (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic want_high_i,
    input wire logic kill_i,
    output gcf_pkg::gcf_phase_cmd_t cmd_o
);
    logic [gcf_pkg::CNT_W-1:0] tmr_q;
    logic side_q; // Side last requested, 1 = high
    gcf_pkg::gcf_phase_cmd_t cmd_q;

    // Timer reloads on every command edge: dead time on turn-off, min pulse on turn-on
    always_ff @(posedge clk_i) begin
        if (!rstn_i || kill_i) begin
            tmr_q <= gcf_pkg::CNT_W'(gcf_pkg::DEAD_CYC);
        end else if (cmd_q.high_side_command || cmd_q.low_side_command) begin
            if (side_q != want_high_i && tmr_q == '0) begin
                tmr_q <= gcf_pkg::CNT_W'(gcf_pkg::DEAD_CYC);
            end else if (tmr_q != '0) begin
                tmr_q <= tmr_q - 1'b1;
            end
        end else if (tmr_q == '0) begin
            tmr_q <= gcf_pkg::CNT_W'(gcf_pkg::MIN_PULSE_CYC);
        end else begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // Switching: on side held min pulse, then off, then dead time, then on
    always_ff @(posedge clk_i) begin
        if (!rstn_i || kill_i) begin
            cmd_q <= '0;
            side_q <= 1'b0;
        end else if (cmd_q.high_side_command || cmd_q.low_side_command) begin
            // Leave the on side only after the minimum pulse
            if (side_q != want_high_i && tmr_q == '0) begin
                cmd_q <= '0;
            end
        end else if (tmr_q == '0) begin
            // Both off long enough; never both high at once
            cmd_q.high_side_command <= want_high_i;
            cmd_q.low_side_command <= !want_high_i;
            side_q <= want_high_i;
        end
    end

    assign cmd_o = cmd_q;

    a_no_overlap: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(cmd_q.high_side_command && cmd_q.low_side_command))
        else $error("both commands high");
    a_dead_time: assert property (@(posedge clk_i) disable iff (!rstn_i || kill_i)
        $fell(cmd_q.low_side_command) |-> !cmd_q.high_side_command [*8])
        else $error("dead time too short");
endmodule : gcf_phase

// ==== design/gcf_ctrl.sv ====
/*
 * Gate command controller: produces the six phase commands for a three-phase
 * inverter driver from per-phase duty inputs, watches the shared open-drain
 * fault line, drops all commands on a fault and waits before restarting.
 * Assumes FAULT_OUT_N_I is synchronous to REF_CLK_I and pulled up outside.
 */
module gcf_ctrl #(
    parameter int unsigned RESUME_WAIT = gcf_pkg::RESUME_WAIT_CYC
) (
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic ENABLE_I,
    input wire logic [gcf_pkg::NPH*gcf_pkg::DUTY_W-1:0] DUTY_I,
    input wire logic FAULT_OUT_N_I,
    output logic [gcf_pkg::NPH-1:0] HIGH_SIDE_COMMAND_O,
    output logic [gcf_pkg::NPH-1:0] LOW_SIDE_COMMAND_O,
    output logic RUNNING_O,
    output logic TRIPPED_O
);
    gcf_pkg::gcf_state_t state_q;
    logic [gcf_pkg::WAIT_W-1:0] wait_q;
    logic [gcf_pkg::CNT_W-1:0] carrier_q;
    logic [gcf_pkg::NPH-1:0] want_high;
    logic kill;
    logic fault;
    gcf_pkg::gcf_phase_cmd_t cmd [gcf_pkg::NPH];

    // Fault line is active low; device only pulls it low
    assign fault = !FAULT_OUT_N_I;

    // Kill reacts the same cycle a fault appears, not a cycle later
    assign kill = fault || state_q != gcf_pkg::ST_RUN;

    // Carrier counter, period fixed at the fastest allowed rate
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I || state_q != gcf_pkg::ST_RUN) begin
            carrier_q <= '0;
        end else if (carrier_q == gcf_pkg::CNT_W'(gcf_pkg::MIN_PERIOD_CYC - 1)) begin
            carrier_q <= '0;
        end else begin
            carrier_q <= carrier_q + 1'b1;
        end
    end

    // Controller state
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            state_q <= gcf_pkg::ST_IDLE;
            wait_q <= '0;
        end else begin
            unique case (state_q)
                gcf_pkg::ST_IDLE: begin
                    if (ENABLE_I && !fault) state_q <= gcf_pkg::ST_RUN;
                end
                gcf_pkg::ST_RUN: begin
                    if (fault) state_q <= gcf_pkg::ST_TRIP;
                    else if (!ENABLE_I) state_q <= gcf_pkg::ST_IDLE;
                end
                gcf_pkg::ST_TRIP: begin
                    // Wait timing starts once the line has released
                    if (!fault) begin
                        state_q <= gcf_pkg::ST_WAIT;
                        wait_q <= gcf_pkg::WAIT_W'(RESUME_WAIT);
                    end
                end
                gcf_pkg::ST_WAIT: begin
                    // A new fault restarts the wait from the top
                    if (fault) state_q <= gcf_pkg::ST_TRIP;
                    else if (wait_q <= gcf_pkg::WAIT_W'(1)) state_q <= gcf_pkg::ST_IDLE;
                    else wait_q <= wait_q - 1'b1;
                end
            endcase
        end
    end

    // One phase generator per phase
    genvar p;
    generate
        for (p = 0; p < gcf_pkg::NPH; p++) begin : g_phase
            logic [gcf_pkg::DUTY_W-1:0] duty;
            assign duty = DUTY_I[p*gcf_pkg::DUTY_W +: gcf_pkg::DUTY_W];
            assign want_high[p] = carrier_q < duty;
            gcf_phase u_phase (
                .clk_i(REF_CLK_I),
                .rstn_i(RSTN_I),
                .want_high_i(want_high[p]),
                .kill_i(kill),
                .cmd_o(cmd[p])
            );
            // Commands gated combinationally so a fault drops them at once
            assign HIGH_SIDE_COMMAND_O[p] = cmd[p].high_side_command && !kill;
            assign LOW_SIDE_COMMAND_O[p] = cmd[p].low_side_command && !kill;
        end
    endgenerate

    assign RUNNING_O = state_q == gcf_pkg::ST_RUN;
    assign TRIPPED_O = state_q == gcf_pkg::ST_TRIP || state_q == gcf_pkg::ST_WAIT;

    a_fault_stops: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        fault |-> (HIGH_SIDE_COMMAND_O == '0 && LOW_SIDE_COMMAND_O == '0))
        else $error("commands active during fault");
    a_trip_entry: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        (state_q == gcf_pkg::ST_RUN && fault) |=> state_q == gcf_pkg::ST_TRIP)
        else $error("fault not latched");
    a_wait_holds: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        $rose(TRIPPED_O) |-> !RUNNING_O [*8])
        else $error("restart too soon");
    a_no_shoot: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        (HIGH_SIDE_COMMAND_O & LOW_SIDE_COMMAND_O) == '0)
        else $error("shoot-through commanded");
endmodule : gcf_ctrl

// ==== tb/gcf_dev_model.sv ====
/* Behavioural gate driver on the far side of the controller.
   Assumes its inputs change away from rising edges of clk_i. */
module gcf_dev_model #(
    parameter int BLANK = 5,
    parameter int HOLD = 300,
    parameter int FILT = 8
) (
    input wire logic clk_i,
    input wire logic [2:0] high_side_command_i,
    input wire logic [2:0] low_side_command_i,
    input wire logic logic_supply_lockout_i,
    input wire logic overcurrent_sense_i,
    output logic fault_out_n_o,
    output logic [2:0] high_gate_drive_o,
    output logic [2:0] low_gate_drive_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int blank_q = 0;
    int hold_q = 0;
    int both_q = 0;
    logic [2:0] hi_q = 3'h0;
    logic [2:0] lo_q = 3'h0;
    logic fault_pulldown_switch;
    // Edge-set latches; an undriven pin reads low
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < 3; p++) begin
            hi_q[p] <= high_side_command_i[p] === 1'b1;
            lo_q[p] <= low_side_command_i[p] === 1'b1;
        end
    end
    // Blanking keeps short spikes from tripping; hold outlasts the spike
    always_ff @(posedge clk_i) begin
        blank_q <= overcurrent_sense_i ? blank_q + 1 : 0;
        if (overcurrent_sense_i && blank_q >= BLANK - 1) hold_q <= HOLD;
        else if (hold_q > 0) hold_q <= hold_q - 1;
        both_q <= |(hi_q & lo_q) ? both_q + 1 : 0;
    end
    // Driven low on a fault and driven high otherwise; no outside pull-up is modelled
    assign fault_pulldown_switch = logic_supply_lockout_i || hold_q > 0 || both_q > FILT;
    assign fault_out_n_o = fault_pulldown_switch ? 1'b0 : 1'b1;
    assign high_gate_drive_o = fault_out_n_o ? hi_q : 3'h0;
    assign low_gate_drive_o = fault_out_n_o ? lo_q : 3'h0;
endmodule : gcf_dev_model

// ==== tb/gcf_ctrl_tb.sv ====
/* Bench for gcf_ctrl: duty table, then trips, restart and reset.
   Assumes the device model shares the reference clock. */
module gcf_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [29:0] duty;
        logic [2:0] hi;
        logic [2:0] lo;
    } gcf_row_t;
    localparam gcf_row_t ROWS [2] = '{'{{10'h1F4, 10'h0FA, 10'h000}, 3'h6, 3'h3},
        '{{10'h0FA, 10'h000, 10'h1F4}, 3'h5, 3'h6}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic enable = 1'b0;
    logic [29:0] duty = 30'h0;
    logic lockout = 1'b0;
    logic overcurrent_sense = 1'b0;
    logic fault_n;
    logic [2:0] hi_cmd;
    logic [2:0] lo_cmd;
    logic running;
    logic tripped;
    logic [2:0] seen [2] = '{default: 3'h0};
    logic [2:0] cmd_q [2] = '{default: 3'h0};
    int on_n [2][3] = '{default: 0};
    int off_n [2][3] = '{default: 100};
    int bad_count = 0;
    int compares = 0;
    int n;
    gcf_ctrl #(.RESUME_WAIT(50)) i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .ENABLE_I(enable), .DUTY_I(duty),
        .FAULT_OUT_N_I(fault_n), .HIGH_SIDE_COMMAND_O(hi_cmd), .LOW_SIDE_COMMAND_O(lo_cmd),
        .RUNNING_O(running), .TRIPPED_O(tripped));
    gcf_dev_model i_dev (.clk_i(clk), .high_side_command_i(hi_cmd), .low_side_command_i(lo_cmd),
        .logic_supply_lockout_i(lockout), .overcurrent_sense_i(overcurrent_sense), .fault_out_n_o(fault_n),
        .high_gate_drive_o(), .low_gate_drive_o());
    task automatic end_sim();
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic cycles(input int k);
        repeat (k) @(negedge clk);
    endtask : cycles
    // Bounded wait on running (w 0) or the fault line
    task automatic wait_for(input int w, input logic v);
        n = 0;
        while ((w == 0 ? running : fault_n) !== v) begin
            cycles(1);
            n++;
            if (n > 3000) begin
                bad_count++;
                end_sim();
            end
        end
    endtask : wait_for
    initial begin
        forever #50 clk = ~clk;
    end
    // Watch the wire after the falling-edge drives settle
    always @(negedge clk) begin
        logic c;
        #20;
        if (fault_n === 1'b0) check("cmds in fault", {hi_cmd, lo_cmd}, 6'h00);
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 3; p++) begin
                c = s ? lo_cmd[p] : hi_cmd[p];
                if (c && !cmd_q[s][p]) check("dead time", off_n[1 - s][p] >= 9, 1'b1);
                if (!c && cmd_q[s][p] && fault_n && rstn) check("pulse", on_n[s][p] >= 5, 1'b1);
                on_n[s][p] = c ? on_n[s][p] + 1 : 0;
                off_n[s][p] = c ? 0 : off_n[s][p] + 1;
                cmd_q[s][p] = c;
                seen[s][p] = seen[s][p] | c;
            end
        end
    end
    initial begin
        cycles(12);
        check("reset outs", {hi_cmd, lo_cmd, running, tripped}, 8'h00);
        rstn = 1'b1;
        cycles(1);
        enable = 1'b1;
        wait_for(0, 1'b1);
        for (int r = 0; r < 2; r++) begin
            duty = ROWS[r].duty;
            cycles(600);
            seen = '{default: 3'h0};
            cycles(1000);
            check("high seen", seen[0], ROWS[r].hi);
            check("low seen", seen[1], ROWS[r].lo);
        end
        // Overcurrent trip, then the restart wait
        overcurrent_sense = 1'b1;
        cycles(6);
        overcurrent_sense = 1'b0;
        check("trip", {tripped, running}, 2'h2);
        wait_for(1, 1'b1);
        wait_for(0, 1'b1);
        check("resume wait", n >= 50, 1'b1);
        // Lockout trip; enable is dropped as the lockout releases, before the wait, then raised again to restart
        lockout = 1'b1;
        cycles(3);
        check("lock trip", tripped, 1'b1);
        enable = 1'b0;
        lockout = 1'b0;
        cycles(100);
        check("idle", running, 1'b0);
        enable = 1'b1;
        wait_for(0, 1'b1);
        rstn = 1'b0;
        cycles(2);
        check("mid reset", {hi_cmd, lo_cmd, running, tripped}, 8'h00);
        end_sim();
    end
endmodule : gcf_ctrl_tb
